// >>> rtl/zcp_regbank.sv
// Purpose: zone controller register bank as seen by the line controller
// Assumes: classic Wishbone slave, 32-bit data, 16-bit registers in the low half
// Notes: one clock, synchronous active high reset
//
// Implementation choice: the Wishbone register port.
`include "zcp_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module zcp_regbank #(
  parameter int unsigned HB_HALF_CYCLES = `ZCP_HB_HALF_MS * `ZCP_CLK_KHZ
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sensor port pins, asynchronous
  input wire zcp_pkg::zcp_sens_t sens_pin_i,
  // auto-configuration result
  input wire logic autocfg_done_i,
  input wire logic [1:0] sens_inv_i,
  // stop causes, levels
  input wire zcp_pkg::zcp_stop_t stop_i,
  // zone status words
  input wire logic up_zs_vld_i,
  input wire logic [15:0] up_zs_i,
  input wire logic dn_zs_vld_i,
  input wire logic [15:0] dn_zs_i,
  // reverse discharge capture
  input wire logic rev_dis_i,
  input wire logic [15:0] rev_w2_i,
  // tracking data to the zones
  output zcp_pkg::zcp_trk_t up_trk_o,
  output logic up_trk_load_o,
  output logic [15:0] dn_trk_w1_o,
  output logic dn_trk_load_o,
  // interrupt
  output logic irq_o
);
  import zcp_pkg::*;

  if (HB_HALF_CYCLES < 1) begin : g_chk
    $error("heartbeat half period must be at least one cycle");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction : merge16

  function automatic logic zs_legal(input logic [15:0] w);
    return (w[7:0] >= `ZCP_ZS_MIN) && (w[7:0] <= `ZCP_ZS_MAX);
  endfunction : zs_legal

  // ****************************************
  // bus decode
  // ****************************************
  wire [7:0] idx = wb_adr_i[9:2];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire hit_upw1 = (idx == `ZCP_IDX_UPW1);
  wire hit_upw2 = (idx == `ZCP_IDX_UPW2);
  wire hit_dnw1 = (idx == `ZCP_IDX_DNW1);
  wire hit_msk = (idx == `ZCP_IDX_IRQMSK);
  wire hit_st = (idx == `ZCP_IDX_IRQST);
  // only the output registers and the mask accept writes
  wire wr_upw1 = wr & hit_upw1;
  wire wr_upw2 = wr & hit_upw2;
  wire wr_dnw1 = wr & hit_dnw1;
  wire wr_msk = wr & hit_msk;
  wire rd_st = rd & hit_st;

  // ****************************************
  // sensor synchroniser
  // ****************************************
  zcp_sens_t s1_q;
  zcp_sens_t s2_q;
  logic [1:0] inv_q;
  logic hb;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= sens_pin_i;
      s2_q <= s1_q;
    end
  end

  // polarity held from the first auto-configuration until the next one
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      inv_q <= 2'h0;
    end else if (autocfg_done_i) begin
      inv_q <= sens_inv_i;
    end
  end

  zcp_heartbeat #(
    .HALF_CYCLES(HB_HALF_CYCLES)
  ) u_hb (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .hb_o(hb)
  );

  wire blk_l = s2_q.sig_l ^ inv_q[0];
  wire blk_r = s2_q.sig_r ^ inv_q[1];
  logic [15:0] sens_d;
  always_comb begin
    sens_d = 16'h0000;
    sens_d[`ZCP_SENS_AUX_L] = s2_q.aux_l;
    sens_d[`ZCP_SENS_AUX_R] = s2_q.aux_r;
    sens_d[`ZCP_SENS_SIG_L] = blk_l;
    sens_d[`ZCP_SENS_SIG_R] = blk_r;
    sens_d[`ZCP_SENS_HB] = hb;
  end

  // ****************************************
  // stop status
  // ****************************************
  logic [15:0] stop_d;
  always_comb begin
    stop_d = 16'h0000;
    stop_d[`ZCP_STOP_PEER] = stop_i.peer;
    stop_d[`ZCP_STOP_LINK] = stop_i.link;
    stop_d[`ZCP_STOP_PLC] = stop_i.plc;
    stop_d[`ZCP_STOP_CMD] = stop_i.cmd;
  end

  // ****************************************
  // status registers
  // ****************************************
  logic [15:0] sens_q;
  logic [15:0] stop_q;
  logic [15:0] upzs_q;
  logic [15:0] dnzs_q;
  logic [15:0] revw2_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sens_q <= `ZCP_RST_WORD;
      stop_q <= `ZCP_RST_WORD;
    end else begin
      sens_q <= sens_d;
      stop_q <= stop_d;
    end
  end

  // out of range low bytes are dropped, the high byte passes as given
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      upzs_q <= `ZCP_RST_WORD;
      dnzs_q <= `ZCP_RST_WORD;
    end else begin
      if (up_zs_vld_i && zs_legal(up_zs_i)) begin
        upzs_q <= up_zs_i;
      end
      if (dn_zs_vld_i && zs_legal(dn_zs_i)) begin
        dnzs_q <= dn_zs_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      revw2_q <= `ZCP_RST_WORD;
    end else if (rev_dis_i) begin
      revw2_q <= rev_w2_i;
    end
  end

  // ****************************************
  // tracking output registers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      up_trk_o <= '0;
      dn_trk_w1_o <= `ZCP_RST_WORD;
      up_trk_load_o <= 1'b0;
      dn_trk_load_o <= 1'b0;
    end else begin
      if (wr_upw1) begin
        up_trk_o.w1 <= merge16(up_trk_o.w1, wb_dat_i, wb_sel_i);
      end
      if (wr_upw2) begin
        up_trk_o.w2 <= merge16(up_trk_o.w2, wb_dat_i, wb_sel_i);
      end
      if (wr_dnw1) begin
        dn_trk_w1_o <= merge16(dn_trk_w1_o, wb_dat_i, wb_sel_i);
      end
      up_trk_load_o <= wr_upw1 | wr_upw2;
      dn_trk_load_o <= wr_dnw1;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [`ZCP_EV_W-1:0] ev;
  logic [`ZCP_EV_W-1:0] st_q;
  logic [`ZCP_EV_W-1:0] st_d;
  logic [`ZCP_EV_W-1:0] msk_q;
  wire new_stop = |(stop_d & ~stop_q);
  always_comb begin
    ev = `ZCP_RST_EV;
    ev[`ZCP_EV_REV] = rev_dis_i;
    ev[`ZCP_EV_STOP] = new_stop;
    ev[`ZCP_EV_TRK] = wr_upw1 | wr_upw2 | wr_dnw1;
  end
  // an event in the clearing read's cycle survives the clear
  always_comb begin
    st_d = (rd_st ? `ZCP_RST_EV : st_q) | ev;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q <= `ZCP_RST_EV;
      msk_q <= `ZCP_RST_EV;
      irq_o <= 1'b0;
    end else begin
      st_q <= st_d;
      if (wr_msk) begin
        msk_q <= wb_dat_i[`ZCP_EV_W-1:0];
      end
      irq_o <= |(st_d & (wr_msk ? wb_dat_i[`ZCP_EV_W-1:0] : msk_q));
    end
  end

  // ****************************************
  // read mux and acknowledge
  // ****************************************
  // the reserved word and unmapped indices answer zero rather than stall the bus
  wire [15:0] rd_word =
    (idx == `ZCP_IDX_STOP) ? stop_q :
    (idx == `ZCP_IDX_SENS) ? sens_q :
    (idx == `ZCP_IDX_UPZS) ? upzs_q :
    (idx == `ZCP_IDX_DNZS) ? dnzs_q :
    (idx == `ZCP_IDX_REVW2) ? revw2_q :
    hit_upw1 ? up_trk_o.w1 :
    hit_upw2 ? up_trk_o.w2 :
    hit_dnw1 ? dn_trk_w1_o :
    hit_st ? {13'h0000, st_q} :
    hit_msk ? {13'h0000, msk_q} :
    16'h0000;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= {16'h0000, rd_word};
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  ack_single_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  ack_next_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("request not acknowledged");
  peer_stop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    stop_i.peer |=> stop_q[`ZCP_STOP_PEER]) else $error("peer stop bit missing");
  link_stop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ##1 stop_q[`ZCP_STOP_LINK] == $past(stop_i.link)) else $error("link stop bit wrong");
  plc_stop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !stop_i.plc ##1 !stop_i.plc |-> !stop_q[`ZCP_STOP_PLC]) else $error("plc stop bit stuck");
  cmd_stop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $rose(stop_i.cmd) |=> stop_q[`ZCP_STOP_CMD]) else $error("stop command bit missing");
  stop_rsvd_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (stop_q & 16'hFB1F) == 16'h0000) else $error("stop reserved bit set");
  sens_rsvd_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (sens_q & 16'h7FAA) == 16'h0000) else $error("sensor reserved bit set");
  sens_block_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ##1 sens_q[`ZCP_SENS_SIG_L] == ($past(s2_q.sig_l) ^ $past(inv_q[0])))
    else $error("left sensor not shown as blocked");
  aux_pin_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ##3 sens_q[`ZCP_SENS_AUX_R] == $past(sens_pin_i.aux_r, 3)) else $error("right aux lag");
  rev_cap_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rev_dis_i |=> revw2_q == $past(rev_w2_i)) else $error("reverse word not captured");
  zs_range_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    upzs_q[7:0] <= `ZCP_ZS_MAX && dnzs_q[7:0] <= `ZCP_ZS_MAX) else $error("zone status range");
  up_adopt_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (wr_upw2 && wb_sel_i[1:0] == 2'h3) |=> up_trk_load_o && up_trk_o.w2 == $past(wb_dat_i[15:0]))
    else $error("upstream word 2 not adopted");
  dn_adopt_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (wr_dnw1 && wb_sel_i[1:0] == 2'h3) |=> dn_trk_load_o && dn_trk_w1_o == $past(wb_dat_i[15:0]))
    else $error("downstream word 1 not adopted");
  ro_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (wr && !hit_upw1 && !hit_upw2 && !hit_dnw1) |=> !up_trk_load_o && !dn_trk_load_o)
    else $error("read-only write had an effect");
  irq_set_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rev_dis_i && msk_q[`ZCP_EV_REV] && !wr_msk) |=> irq_o && st_q[`ZCP_EV_REV])
    else $error("reverse event lost");

  rev_c: cover property (@(posedge sys_clk_i) disable iff (srst_i) rev_dis_i ##2 irq_o);
  cmd_c: cover property (@(posedge sys_clk_i) disable iff (srst_i) $rose(stop_q[`ZCP_STOP_CMD]));
  trk_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    up_trk_load_o ##[1:8] dn_trk_load_o);
  clr_c: cover property (@(posedge sys_clk_i) disable iff (srst_i) rd_st && (st_q != 3'h0));
endmodule : zcp_regbank
`default_nettype wire

// >>> rtl/zcp_regs.svh
// Purpose: offsets, field positions, reset values and timing for the zone register bank
// Assumes: word index times four is the Wishbone byte address
// Notes: included by its bare name
`ifndef ZCP_REGS_SVH
`define ZCP_REGS_SVH
// ****************************************
// word indices
// ****************************************
`define ZCP_IDX_STOP 8'h13
`define ZCP_IDX_SENS 8'h23
`define ZCP_IDX_RSVD 8'h24
`define ZCP_IDX_UPZS 8'h30
`define ZCP_IDX_DNZS 8'h31
`define ZCP_IDX_REVW2 8'h7A
`define ZCP_IDX_UPW1 8'h84
`define ZCP_IDX_UPW2 8'h85
`define ZCP_IDX_DNW1 8'h86
`define ZCP_IDX_IRQST 8'h90
`define ZCP_IDX_IRQMSK 8'h91
// ****************************************
// field positions
// ****************************************
`define ZCP_SENS_AUX_L 0
`define ZCP_SENS_AUX_R 2
`define ZCP_SENS_SIG_L 4
`define ZCP_SENS_SIG_R 6
`define ZCP_SENS_HB 15
`define ZCP_STOP_PEER 5
`define ZCP_STOP_LINK 6
`define ZCP_STOP_PLC 7
`define ZCP_STOP_CMD 10
`define ZCP_EV_REV 0
`define ZCP_EV_STOP 1
`define ZCP_EV_TRK 2
`define ZCP_EV_W 3
// ****************************************
// reset values and limits
// ****************************************
`define ZCP_RST_WORD 16'h0000
`define ZCP_RST_EV 3'h0
`define ZCP_ZS_MIN 8'h01
`define ZCP_ZS_MAX 8'h06
// ****************************************
// timing
// ****************************************
`define ZCP_HB_HALF_MS 2000
`define ZCP_CLK_KHZ 25000
`endif

// >>> rtl/zcp_pkg.sv
// Purpose: types shared by the zone register bank
// Assumes: nothing
// Notes: constants live in zcp_regs.svh
package zcp_pkg;
  typedef struct packed {
    logic aux_l;
    logic aux_r;
    logic sig_l;
    logic sig_r;
  } zcp_sens_t;
  typedef struct packed {
    logic peer;
    logic link;
    logic plc;
    logic cmd;
  } zcp_stop_t;
  typedef struct packed {
    logic [15:0] w1;
    logic [15:0] w2;
  } zcp_trk_t;
endpackage : zcp_pkg

// >>> rtl/zcp_heartbeat.sv
// Purpose: square wave heartbeat, HALF_CYCLES high then HALF_CYCLES low
// Assumes: one clock, synchronous reset
// Notes: output starts high after reset
`timescale 1ns/1ns
`default_nettype none
module zcp_heartbeat #(
  parameter int unsigned HALF_CYCLES = 50000000
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // heartbeat level
  output logic hb_o
);
  localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);
  logic [CW-1:0] cnt_q;
  wire wrap = (cnt_q == LAST);

  if (HALF_CYCLES < 1) begin : g_chk
    $error("heartbeat half period must be at least one cycle");
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      hb_o <= 1'b1;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      hb_o <= wrap ? ~hb_o : hb_o;
    end
  end

  hb_bound_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cnt_q <= LAST) else $error("heartbeat counter ran past its half period");
  hb_toggle_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $changed(hb_o) |-> $past(cnt_q) == LAST) else $error("heartbeat toggled off the wrap");
  hb_flip_c: cover property (@(posedge sys_clk_i) disable iff (srst_i) $fell(hb_o));
endmodule : zcp_heartbeat
`default_nettype wire

// >>> testbench/zcp_plc_model.sv
// Purpose: line controller model, classic Wishbone master of the register bank
// Assumes: slave answers each request with a one-cycle registered ack
// Notes: tb_top calls the tasks by hierarchical name
`timescale 1ns/1ns
`default_nettype none
module zcp_plc_model (
  // clock
  input wire logic sys_clk_i,
  // wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [9:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 10'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h00000000;
  end
  // ****************************************
  // bus cycle
  // ****************************************
  task automatic cycle(input logic we, input logic [7:0] idx, input logic [3:0] sel,
                       input logic [15:0] wd, output logic [15:0] rd);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= {idx, 2'b00};
    wb_sel_o <= sel;
    wb_dat_o <= {16'h0000, wd}; // one whole 16-bit integer a register
    do @(posedge sys_clk_i); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i[15:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // released lines show garbage, not the last value
    wb_adr_o <= ~{idx, 2'b00};
    wb_dat_o <= ~{16'h0000, wd};
    @(posedge sys_clk_i);
  endtask : cycle
  task automatic wr(input logic [7:0] idx, input logic [15:0] wd, input logic [3:0] sel);
    logic [15:0] dummy;
    cycle(1'b1, idx, sel, wd, dummy); // tracking words written give one-cycle load pulses
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [15:0] d);
    cycle(1'b0, idx, 4'hF, 16'h0000, d);
  endtask : rd
  // status logic drops the high byte and trusts only the stable code 05
  function automatic logic zone_held(input logic [15:0] zs);
    return (zs & 16'h00FF) == 16'h0005;
  endfunction : zone_held
endmodule : zcp_plc_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: self-checking bench of the zone register bank
// Assumes: read data arrives with a one-cycle ack
// Notes: heartbeat half period cut down to HB cycles
`include "zcp_regs.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import zcp_pkg::*;
  localparam int unsigned HB = 8;
  logic sys_clk, srst, cyc, stb, we, ack, autocfg, up_vld, dn_vld, rev_dis;
  logic up_load, dn_load, irq;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [1:0] inv;
  logic [15:0] up_zs, dn_zs, rev_w2, dn_w1, d, e, f;
  logic [15:0] sx [4] = '{16'h0400, 16'h0080, 16'h0040, 16'h0020};
  zcp_sens_t pins;
  zcp_stop_t stp;
  zcp_trk_t up_trk;
  int n_errors = 0;
  int num_checks = 0;
  int n_up = 0;
  int n_dn = 0;
  zcp_plc_model u_plc (.sys_clk_i(sys_clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));
  zcp_regbank #(.HB_HALF_CYCLES(HB)) u_dut (.sys_clk_i(sys_clk), .srst_i(srst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sens_pin_i(pins),
    .autocfg_done_i(autocfg), .sens_inv_i(inv), .stop_i(stp), .up_zs_vld_i(up_vld),
    .up_zs_i(up_zs), .dn_zs_vld_i(dn_vld), .dn_zs_i(dn_zs), .rev_dis_i(rev_dis),
    .rev_w2_i(rev_w2), .up_trk_o(up_trk), .up_trk_load_o(up_load), .dn_trk_w1_o(dn_w1),
    .dn_trk_load_o(dn_load), .irq_o(irq));
  // ****************************************
  // clock, load pulse counters, ending
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (up_load === 1'b1) n_up++;
    if (dn_load === 1'b1) n_dn++;
  end
  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    srst = 1'b1; pins = '0; stp = '0; inv = 2'b00; autocfg = 1'b0; up_vld = 1'b0;
    dn_vld = 1'b0; up_zs = 16'h0000; dn_zs = 16'h0000; rev_dis = 1'b0; rev_w2 = 16'h0000;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    u_plc.wr(`ZCP_IDX_STOP, 16'hFFFF, 4'h3);
    u_plc.rd(`ZCP_IDX_STOP, d); `CHK(d, 16'h0000)
    u_plc.rd(`ZCP_IDX_RSVD, d); `CHK(d, 16'h0000)
    u_plc.rd(8'h50, d); `CHK(d, 16'h0000)
    u_plc.wr(`ZCP_IDX_UPW1, 16'h1234, 4'h3);
    u_plc.wr(`ZCP_IDX_UPW2, 16'hBEEF, 4'h3);
    `CHK(up_trk, {16'h1234, 16'hBEEF})
    `CHK(n_up, 2)
    u_plc.rd(`ZCP_IDX_UPW2, d); `CHK(d, 16'hBEEF)
    // low lane only, so the high byte must survive
    u_plc.wr(`ZCP_IDX_DNW1, 16'hAAAA, 4'h3);
    u_plc.wr(`ZCP_IDX_DNW1, 16'h5511, 4'h1);
    `CHK(dn_w1, 16'hAA11)
    `CHK(n_dn, 2)
    u_plc.rd(`ZCP_IDX_IRQST, d); `CHK(d, 16'h0004)
    u_plc.rd(`ZCP_IDX_IRQST, d); `CHK(d, 16'h0000)
    rev_w2 <= 16'hC0DE; rev_dis <= 1'b1;
    @(posedge sys_clk);
    rev_w2 <= 16'h3F21; rev_dis <= 1'b0;
    @(posedge sys_clk);
    u_plc.rd(`ZCP_IDX_REVW2, d); `CHK(d, 16'hC0DE)
    `CHK(irq, 1'b0)
    u_plc.wr(`ZCP_IDX_IRQMSK, 16'h0003, 4'h3); `CHK(irq, 1'b1)
    u_plc.rd(`ZCP_IDX_IRQST, d); `CHK(d, 16'h0001)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 4; i++) begin
      stp <= zcp_stop_t'(4'h1 << i);
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'b1)
      u_plc.rd(`ZCP_IDX_STOP, d); `CHK(d, sx[i])
      u_plc.rd(`ZCP_IDX_IRQST, d); `CHK(d, 16'h0002)
      stp <= '0;
      repeat (2) @(posedge sys_clk);
      u_plc.rd(`ZCP_IDX_STOP, d); `CHK(d, 16'h0000)
    end
    // both events masked in: each raises irq until its status is read
    u_plc.wr(`ZCP_IDX_IRQMSK, 16'h0005, 4'h3); `CHK(irq, 1'b0)
    rev_w2 <= 16'h5A5A; rev_dis <= 1'b1;
    @(posedge sys_clk);
    rev_dis <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    u_plc.rd(`ZCP_IDX_IRQST, d); `CHK(d, 16'h0001)
    `CHK(irq, 1'b0)
    u_plc.rd(`ZCP_IDX_REVW2, d); `CHK(d, 16'h5A5A)
    // high lane only, so the low byte must survive
    u_plc.wr(`ZCP_IDX_UPW1, 16'hFF77, 4'h2); `CHK(irq, 1'b1)
    `CHK(up_trk.w1, 16'hFF34)
    u_plc.rd(`ZCP_IDX_IRQST, d); `CHK(d, 16'h0004)
    `CHK(irq, 1'b0)
    // out-of-range low bytes must leave the last good word in place
    e = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      up_zs <= {k[7:0], k[7:0]}; up_vld <= 1'b1;
      @(posedge sys_clk);
      up_vld <= 1'b0;
      @(posedge sys_clk);
      if (k >= 1 && k <= 6) e = {k[7:0], k[7:0]};
      u_plc.rd(`ZCP_IDX_UPZS, d); `CHK(d, e)
    end
    dn_zs <= 16'h8005; dn_vld <= 1'b1;
    @(posedge sys_clk);
    dn_vld <= 1'b0;
    @(posedge sys_clk);
    u_plc.rd(`ZCP_IDX_DNZS, d); `CHK(d, 16'h8005)
    `CHK(u_plc.zone_held(d), 1'b1)
    for (int pol = 0; pol < 4; pol++) begin
      inv <= pol[1:0]; autocfg <= 1'b1;
      @(posedge sys_clk);
      autocfg <= 1'b0;
      for (int p = 0; p < 16; p++) begin
        pins <= zcp_sens_t'(p[3:0]);
        repeat (4) @(posedge sys_clk);
        e = 16'h0000;
        e[0] = p[3];
        e[2] = p[2];
        e[4] = p[1] ^ pol[0];
        e[6] = p[0] ^ pol[1];
        u_plc.rd(`ZCP_IDX_SENS, d); `CHK(d & 16'h7FFF, e)
      end
    end
    // reads taken exactly HB cycles apart see opposite heartbeat levels
    u_plc.rd(`ZCP_IDX_SENS, d);
    repeat (5) @(posedge sys_clk);
    u_plc.rd(`ZCP_IDX_SENS, e); `CHK(e[15], ~d[15])
    repeat (5) @(posedge sys_clk);
    u_plc.rd(`ZCP_IDX_SENS, f); `CHK(f[15], d[15])
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
